// file: tb/pcs_host.sv
// host model: single-byte register master with end-of-transaction pulse
`timescale 1ns/1ns
module pcs_host
    import pcs_pkg::*;
(
    // clock
    input wire logic clk,
    // requests toward the slice
    output pcs_req_type req,
    output logic transaction_end,
    // answers from the slice
    input wire logic [7:0] rdata,
    input wire logic rvalid
);
    // idle bus at time zero
    initial begin
        req = '0;
        transaction_end = 1'b0;
    end
    // each byte is one transaction closed by a stop pulse
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
        @(posedge clk);
        req <= '{wr: w, rd: !w, addr: a, wdata: d};
        @(posedge clk);
        req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d}; // released address and data lines never keep old value
        transaction_end <= 1'b1;
        @(posedge clk);
        transaction_end <= 1'b0;
        q = rvalid ? rdata : 8'hee; // no answer shows as a poison byte
    endtask
endmodule

// file: tb/testbench.sv
// self-checking bench for the control and status register slice
`timescale 1ns/1ns
module testbench
    import pcs_pkg::*;
;
    logic clk = 1'b0;
    logic rst = 1'b1;
    pcs_req_type req;
    logic tend, pwr, ok, adp, usb, btn, pen, l3s, l4s, rv, mo, offr;
    logic [7:0] rd_d, q;
    logic [6:0] duty;
    pcs_route_type route;
    pcs_good_type good;
    int fail_count = 0;
    int n_compared = 0;
    int cycles = 0;
    // clock
    initial forever #5 clk = ~clk;
    pcs_host host(.clk(clk), .req(req), .transaction_end(tend), .rdata(rd_d), .rvalid(rv));
    pcs_regs dut(.clk(clk), .rst(rst), .req(req), .transaction_end(tend), .rdata(rd_d), .rvalid(rv),
        .protected_wr(pwr), .protected_wr_allow(ok), .adapter_present(adp), .usb_supply_present(usb),
        .button_pin(btn), .power_enable_pin(pen), .good_in(good), .linear3_is_switch(l3s),
        .linear4_is_switch(l4s), .duty_percent(duty), .route(route), .mux_output_enable(mo),
        .off_request(offr));
    // ********************
    // shared tasks
    // ********************
    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        n_compared++;
        if (s !== e) begin
            fail_count++;
            $display("[FAIL] %0t seen %h want %h", $time, s, e);
        end
    endtask
    task automatic stop_test;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        host.xfer(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        host.xfer(1'b0, a, 8'h00, q);
        chk(q, e);
    endtask
    // inputs in order adapter, usb, button pin, power enable
    task automatic set_in(input logic [3:0] v);
        @(posedge clk);
        {adp, usb, btn, pen} <= v;
    endtask
    task automatic set_pg(input logic [8:0] v);
        @(posedge clk);
        {good, l3s, l4s} <= v;
    endtask
    // one-cycle protected write attempt, allow sampled 1 ns after the clock edge
    task automatic prot(input logic e);
        @(posedge clk);
        pwr <= 1'b1;
        #1 chk({7'h00, ok}, {7'h00, e});
        @(posedge clk);
        pwr <= 1'b0;
    endtask
    // ********************
    // scenarios
    // ********************
    task automatic t_reset;
        chk({1'b0, duty}, 8'h01);
        chk({2'b00, route, mo}, 8'h00);
        for (int a = 8; a < 13; a++)
            rd(8'(a), 8'h00);
        $display("reset test done");
    endtask
    task automatic t_duty;
        logic [6:0] c [6] = '{7'h00, 7'h01, 7'h62, 7'h63, 7'h64, 7'h7f};
        foreach (c[i]) begin
            wr(ADDR_BACKLIGHT_DUTY, {1'b1, c[i]});
            chk({1'b0, duty}, (c[i] < 7'h64) ? {1'b0, c[i]} + 8'h01 : 8'h00);
            rd(ADDR_BACKLIGHT_DUTY, {1'b0, c[i]});
        end
        $display("duty test done");
    endtask
    task automatic t_mux;
        for (int s = 0; s < 8; s++) begin
            wr(ADDR_ANALOG_SELECT, 8'hf8 | 8'(s));
            chk({2'b00, route, mo}, (s > 0 && s < 6) ? {2'b00, 5'h10 >> (s - 1), 1'b1} : 8'h00);
            rd(ADDR_ANALOG_SELECT, 8'(s));
        end
        $display("mux test done");
    endtask
    task automatic t_status;
        set_in(4'h9);
        wr(ADDR_SYSTEM_STATUS, 8'h7f);
        rd(ADDR_SYSTEM_STATUS, 8'h09);
        set_in(4'h7);
        rd(ADDR_SYSTEM_STATUS, 8'h04);
        $display("status test done");
    endtask
    task automatic t_off;
        int n;
        wr(ADDR_SYSTEM_STATUS, 8'h80);
        rd(ADDR_SYSTEM_STATUS, 8'h84);
        set_in(4'h6);
        n = 0;
        while (offr !== 1'b1 && n < 8) begin
            @(posedge clk);
            n++;
        end
        chk({7'h00, offr}, 8'h01);
        rd(ADDR_SYSTEM_STATUS, 8'h04);
        $display("off test done");
    endtask
    task automatic t_key;
        wr(ADDR_WRITE_UNLOCK_KEY, 8'h7c);
        prot(1'b0);
        rd(ADDR_WRITE_UNLOCK_KEY, 8'h7c);
        wr(ADDR_WRITE_UNLOCK_KEY, UNLOCK_KEY_VALUE);
        prot(1'b1);
        wr(ADDR_BACKLIGHT_DUTY, 8'h05);
        rd(ADDR_WRITE_UNLOCK_KEY, 8'h00);
        prot(1'b0);
        $display("key test done");
    endtask
    task automatic t_good;
        set_pg({7'h55, 2'b00});
        wr(ADDR_REGULATOR_GOOD, 8'hff);
        rd(ADDR_REGULATOR_GOOD, 8'h55);
        set_pg({7'h00, 2'b10});
        rd(ADDR_REGULATOR_GOOD, 8'h40);
        set_pg({7'h00, 2'b01});
        rd(ADDR_REGULATOR_GOOD, 8'h20);
        rd(8'h0d, 8'h00);
        $display("good test done");
    endtask
    // main sequence
    initial begin
        {pwr, adp, usb, btn, pen, good, l3s, l4s} = 14'h0600;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        t_reset;
        t_duty;
        t_mux;
        t_status;
        t_off;
        t_key;
        t_good;
        stop_test;
    end
    // hang guard, far above the fewer than two hundred cycles needed
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            fail_count++;
            stop_test;
        end
    end
endmodule

// file: verilog/pcs_pkg.sv
// package: register map, field positions and types of the control/status register slice
package pcs_pkg;
    // register addresses
    localparam logic [7:0] ADDR_BACKLIGHT_DUTY = 8'h08;
    localparam logic [7:0] ADDR_ANALOG_SELECT = 8'h09;
    localparam logic [7:0] ADDR_SYSTEM_STATUS = 8'h0a;
    localparam logic [7:0] ADDR_WRITE_UNLOCK_KEY = 8'h0b;
    localparam logic [7:0] ADDR_REGULATOR_GOOD = 8'h0c;
    // reset values
    localparam logic [7:0] RESET_REG = 8'h00;
    // field positions
    localparam int STATUS_OFF_BIT = 7;
    localparam int STATUS_ADAPTER_BIT = 3;
    localparam int STATUS_USB_BIT = 2;
    localparam int STATUS_BUTTON_BIT = 0;
    // duty field
    localparam logic [6:0] DUTY_MAX_CODE = 7'h63;
    localparam logic [7:0] DUTY_ZERO_PCT = 8'h00;
    // unlock key value
    localparam logic [7:0] UNLOCK_KEY_VALUE = 8'h7d;
    // analog source select codes
    typedef enum logic [2:0] {
        SRC_OFF0 = 3'h0,
        SRC_BATTERY = 3'h1,
        SRC_SYSTEM_RAIL = 3'h2,
        SRC_TEMP_SENSE = 3'h3,
        SRC_CHARGE_CURRENT = 3'h4,
        SRC_EXTERNAL = 3'h5,
        SRC_OFF6 = 3'h6,
        SRC_OFF7 = 3'h7
    } pcs_source_type;
    // register access request from the serial front end
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } pcs_req_type;
    // regulator status inputs
    typedef struct packed {
        logic linear3_good;
        logic linear4_good;
        logic buck1_good;
        logic buck2_good;
        logic buck3_good;
        logic linear1_good;
        logic linear2_good;
    } pcs_good_type;
    // analog mux routing: one-hot source enables
    typedef struct packed {
        logic battery;
        logic system_rail;
        logic temp_sense_voltage;
        logic charge_current_monitor;
        logic external_analog_input;
    } pcs_route_type;
endpackage

// file: verilog/pcs_regs.sv
// module: control and status register slice at addresses 0x08..0x0c
`timescale 1ns/1ns
module pcs_regs
    import pcs_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // register access, one request per cycle, from the serial front end
    input wire pcs_req_type req,
    input wire logic transaction_end,
    output logic [7:0] rdata,
    output logic rvalid,
    // protected-register write gate for registers outside this slice
    input wire logic protected_wr,
    output logic protected_wr_allow,
    // device status inputs
    input wire logic adapter_present,
    input wire logic usb_supply_present,
    input wire logic button_pin,
    input wire logic power_enable_pin,
    input wire pcs_good_type good_in,
    input wire logic linear3_is_switch,
    input wire logic linear4_is_switch,
    // controlled functions
    output logic [6:0] duty_percent,
    output pcs_route_type route,
    output logic mux_output_enable,
    output logic off_request
);

    // ******************************
    // register state
    // ******************************
    logic [6:0] duty_code;
    logic [2:0] analog_source_sel;
    logic off_pending;
    logic [7:0] unlock_key;
    logic key_armed;
    logic next_key_armed;
    logic [7:0] next_rdata;
    logic [6:0] next_duty_code;
    logic [2:0] next_analog_source_sel;
    logic next_off_pending;
    logic [7:0] next_unlock_key;
    logic key_is_valid;
    logic off_taken;
    logic [7:0] read_mux;

    // duty code to percent
    // maps a duty code to percent; codes past 99 mean dark
    function automatic logic [6:0] duty_to_percent(input logic [6:0] code);
        if (code <= DUTY_MAX_CODE) begin
            duty_to_percent = code + 7'd1;
        end else begin
            duty_to_percent = DUTY_ZERO_PCT[6:0];
        end
    endfunction

    // reads the status register image
    function automatic logic [7:0] status_image(input logic off_b, input logic ac, input logic usb,
                                                input logic pin);
        status_image = 8'h00;
        status_image[STATUS_OFF_BIT] = off_b;
        status_image[STATUS_ADAPTER_BIT] = ac;
        status_image[STATUS_USB_BIT] = usb;
        status_image[STATUS_BUTTON_BIT] = ~pin;
    endfunction

    assign key_is_valid = (unlock_key == UNLOCK_KEY_VALUE);
    // request taken once power enable is low
    assign off_taken = off_pending && !power_enable_pin;

    // next-state for writable fields
    always_comb begin
        next_duty_code = duty_code;
        next_analog_source_sel = analog_source_sel;
        next_off_pending = off_pending;
        next_unlock_key = unlock_key;
        next_key_armed = key_armed;
        // armed once the key-write transaction itself has ended
        if (transaction_end) begin
            next_key_armed = (unlock_key != RESET_REG) && !key_armed;
        end
        // self-clear once taken; a fresh write the same cycle wins
        if (off_taken) begin
            next_off_pending = 1'b0;
        end
        // key returns to zero after the next transaction
        if (transaction_end && key_armed) begin
            next_unlock_key = RESET_REG;
        end
        if (req.wr) begin
            // only writable bits are stored, others dropped
            case (req.addr)
                ADDR_BACKLIGHT_DUTY: begin
                    next_duty_code = req.wdata[6:0];
                end
                ADDR_ANALOG_SELECT: begin
                    next_analog_source_sel = req.wdata[2:0];
                end
                ADDR_SYSTEM_STATUS: begin
                    if (req.wdata[STATUS_OFF_BIT]) begin
                        next_off_pending = 1'b1;
                    end
                end
                ADDR_WRITE_UNLOCK_KEY: begin
                    next_unlock_key = req.wdata;
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            duty_code <= 7'h00;
            analog_source_sel <= 3'h0;
            off_pending <= 1'b0;
            unlock_key <= RESET_REG;
            key_armed <= 1'b0;
        end else begin
            duty_code <= next_duty_code;
            analog_source_sel <= next_analog_source_sel;
            off_pending <= next_off_pending;
            unlock_key <= next_unlock_key;
            key_armed <= next_key_armed;
        end
    end

    // protected writes pass while a valid key is armed, until the next transaction ends
    assign protected_wr_allow = protected_wr && key_is_valid && key_armed;

    // ******************************
    // read path
    // ******************************
    // reserved bits held at zero by construction
    always_comb begin
        case (req.addr)
            ADDR_BACKLIGHT_DUTY: read_mux = {1'b0, duty_code};
            ADDR_ANALOG_SELECT: read_mux = {5'h00, analog_source_sel};
            ADDR_SYSTEM_STATUS: read_mux = status_image(off_pending, adapter_present, usb_supply_present,
                                                        button_pin);
            ADDR_WRITE_UNLOCK_KEY: read_mux = unlock_key;
            ADDR_REGULATOR_GOOD: read_mux = {1'b0, good_in.linear3_good | linear3_is_switch,
                                             good_in.linear4_good | linear4_is_switch, good_in.buck1_good,
                                             good_in.buck2_good, good_in.buck3_good, good_in.linear1_good,
                                             good_in.linear2_good};
            default: read_mux = 8'h00;
        endcase
        // idle bus returns zero so a stale byte never looks valid
        next_rdata = req.rd ? read_mux : 8'h00;
    end

    // read data registered; one cycle after the request
    always_ff @(posedge clk) begin
        if (rst) begin
            rdata <= 8'h00;
            rvalid <= 1'b0;
        end else begin
            rdata <= next_rdata;
            rvalid <= req.rd;
        end
    end

    // ******************************
    // controlled outputs
    // ******************************
    // outputs follow the stored fields the cycle after the write
    always_comb begin
        duty_percent = duty_to_percent(duty_code);
        route = '0;
        case (pcs_source_type'(analog_source_sel))
            SRC_BATTERY: route.battery = 1'b1;
            SRC_SYSTEM_RAIL: route.system_rail = 1'b1;
            SRC_TEMP_SENSE: route.temp_sense_voltage = 1'b1;
            SRC_CHARGE_CURRENT: route.charge_current_monitor = 1'b1;
            SRC_EXTERNAL: route.external_analog_input = 1'b1;
            default: route = '0;
        endcase
        mux_output_enable = |route;
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            off_request <= 1'b0;
        end else begin
            off_request <= off_taken;
        end
    end

    // ******************************
    // checks
    // ******************************
    a_duty_zero_high: assert property (@(posedge clk) disable iff (rst)
        (duty_code > 7'd99) |-> (duty_percent == 7'd0)) else $error("duty above 99 not dark");
    a_duty_low_map: assert property (@(posedge clk) disable iff (rst)
        (duty_code <= 7'd99) |-> (duty_percent == duty_code + 7'd1)) else $error("duty map wrong");
    a_mux_off_codes: assert property (@(posedge clk) disable iff (rst)
        (analog_source_sel == 3'd0 || analog_source_sel >= 3'd6) |-> !mux_output_enable)
        else $error("mux should be hi-z");
    a_off_taken: assert property (@(posedge clk) disable iff (rst)
        (off_pending && !power_enable_pin && !req.wr) |=> (!off_pending && off_request))
        else $error("off not taken");
    a_status_read: assert property (@(posedge clk) disable iff (rst)
        (req.rd && req.addr == ADDR_SYSTEM_STATUS) |=> (rdata[0] == !$past(button_pin) && rdata[6:4] == 3'h0))
        else $error("status read wrong");
    a_key_gate: assert property (@(posedge clk) disable iff (rst)
        protected_wr_allow |-> (unlock_key == 8'h7d)) else $error("protected write without key");
    a_key_clear: assert property (@(posedge clk) disable iff (rst)
        (key_armed && transaction_end && !req.wr) |=> (unlock_key == 8'h00)) else $error("key not cleared");
    a_good_reserved: assert property (@(posedge clk) disable iff (rst)
        (req.rd && req.addr == ADDR_REGULATOR_GOOD) |=> !rdata[7]) else $error("good bit 7 set");
endmodule
